// ### shared/svp_pkg.sv
package svp_pkg;
  // processing time base
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_US = 5000;
  localparam int unsigned TICK_CYCLES_DFLT = (CLK_HZ / 1_000_000) * TICK_US;
  localparam logic [18:0] TICK_CNT_ONE = 19'h00001;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PICKUP = 8'h04;
  localparam logic [7:0] OFS_UNDER_BLOCK_LEVEL = 8'h08;
  localparam logic [7:0] OFS_DTDLY = 8'h0c;
  localparam logic [7:0] OFS_KDIAL = 8'h10;
  localparam logic [7:0] OFS_AEXP = 8'h14;
  localparam logic [7:0] OFS_RELDLY = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_MAG = 8'h20;
  localparam logic [7:0] OFS_RATIO = 8'h24;
  localparam logic [7:0] OFS_EXPECT = 8'h28;
  localparam logic [7:0] OFS_REMAIN = 8'h2c;

  // control field positions
  localparam int unsigned CB_SEQ = 0;
  localparam int unsigned CB_UNDER = 1;
  localparam int unsigned CB_MODE_LO = 2;
  localparam int unsigned CB_MODE_HI = 3;
  localparam int unsigned CB_DLYREL = 4;
  localparam int unsigned CB_CALCRST = 5;
  localparam int unsigned CB_CONT = 6;
  localparam int unsigned CB_FORCE_EN = 7;
  localparam int unsigned CB_FORCE_LO = 8;
  localparam int unsigned CB_FORCE_HI = 9;
  localparam logic [9:0] CTRL_RST = 10'h074;

  // timing modes and forced status codes
  typedef enum logic [1:0] {SVP_INSTANT, SVP_DEFINITE, SVP_INVERSE, SVP_MODE_RSV} svp_mode_t;
  typedef enum logic [1:0] {SVP_F_NORMAL, SVP_F_START, SVP_F_TRIP, SVP_F_BLOCKED} svp_force_t;

  // settings in 0.01 %Un, 0.01 s, 0.01 or 5 ms ticks
  localparam logic [15:0] PICKUP_RST = 16'h2904;
  localparam logic [15:0] PICKUP_MIN = 16'h01f4;
  localparam logic [15:0] PICKUP_MAX = 16'h3a98;
  localparam logic [15:0] UNDER_BLOCK_LEVEL_RST = 16'h01f4;
  localparam logic [15:0] UNDER_BLOCK_LEVEL_MAX = 16'h1f40;
  localparam logic [18:0] DTDLY_RST = 19'h00008;
  localparam logic [18:0] TIME_MAX = 19'h57e40;
  localparam logic [12:0] KDIAL_RST = 13'h0005;
  localparam logic [12:0] KDIAL_MAX = 13'h1770;
  localparam logic [11:0] AEXP_RST = 12'h064;
  localparam logic [11:0] AEXP_MAX = 12'h9c4;
  localparam logic [11:0] AEXP_UNIT = 12'h064;
  localparam logic [14:0] RELDLY_RST = 15'h000c;
  localparam logic [14:0] RELDLY_MAX = 15'h7530;

  // arithmetic constants
  localparam logic signed [17:0] ROT_COS = 18'sh06ed9;
  localparam int unsigned ROT_SHIFT = 15;
  localparam logic signed [17:0] THIRD = 18'sh05555;
  localparam int unsigned THIRD_SHIFT = 16;
  localparam int unsigned RQ = 12;
  localparam logic [31:0] RQ_ONE = 32'h0000_1000;
  localparam logic [31:0] RQ_CAP = 32'h0100_0000;
  localparam logic [6:0] PCT = 7'h64;
  localparam logic [6:0] HYS_OVER = 7'h61;
  localparam logic [6:0] HYS_UNDER = 7'h67;
  localparam logic [16:0] RATIO_MAX = 17'h1e848;
  localparam logic [1:0] TICKS_PER_CS = 2'h2;
  localparam logic [5:0] DIV_STEPS = 6'h20;
  localparam logic [3:0] SQRT_TOP = 4'hf;
endpackage

// ### rtl/svp_seq_voltage_stage.sv
// Summary of operation
// - positive sequence is third of V1 plus V2 at 120 plus V3 at 240.
// - negative sequence is third of V1 plus V2 at 240 plus V3 at 120.
// - works on fundamental phasors refreshed every 5 ms.
// - control bit chooses positive or negative sequence as supervised voltage.
// - forcing enable plus force code override status outputs; default normal.
// - direction bit chooses over or under pick-up; default over.
// - pick-up level 5.00 to 150.00 %Un in 0.01 steps, default 105.
// - over direction drops out only below 97 percent of level.
// - under direction drops out only above 103 percent of level.
// - pick-up asserts on crossing the level, checked once per 5 ms processing tick.
// - settings change live without stopping the stage.
// - under block level 0 to 80 %Un, default 5, under only.
// - below block level tripping is held off until all lines exceed pick-up level.
// - block level zero disables under blocking.
// - expected operating time readable in 5 ms steps, tracks voltage.
// - remaining time to trip readable in 5 ms steps.
// - ratio of voltage to level readable in hundredths.
// - blocking input sampled at start of each processing cycle.
// - pick-up without blocking raises start and runs the timer.
// - pick-up under blocking raises blocked only, no timing.
// - blocking during start clears start via release handling.
// - instant, definite and inverse trip timing modes.
// - inverse time k over ratio power minus one, or one minus.
// - delayed release holds start for release time after drop-out.
//
// The implementer's own choices: the address map and the APB register port.
module svp_seq_voltage_stage #(
  parameter int unsigned TICK_CYCLES = svp_pkg::TICK_CYCLES_DFLT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [15:0] ph1_re,
  input wire logic signed [15:0] ph1_im,
  input wire logic signed [15:0] ph2_re,
  input wire logic signed [15:0] ph2_im,
  input wire logic signed [15:0] ph3_re,
  input wire logic signed [15:0] ph3_im,
  input wire logic [15:0] line12_mag,
  input wire logic [15:0] line23_mag,
  input wire logic [15:0] line31_mag,
  input wire logic block_in,
  output logic start,
  output logic trip,
  output logic blocked
);
  typedef enum logic [2:0] {
    SVP_IDLE, SVP_SQRT, SVP_RDIV, SVP_POW, SVP_TDIV, SVP_EVAL, SVP_OUT
  } svp_state_t;

  logic [9:0] ctrl_reg;
  logic [15:0] pickup_reg, under_block_level_reg;
  logic [18:0] dtdly_reg, tick_cnt_reg;
  logic [12:0] kdial_reg;
  logic [11:0] aexp_reg;
  logic [14:0] reldly_reg, rel_cnt_reg;
  logic [31:0] prdata_reg;
  logic tick, wr_en, addr_ok;
  svp_state_t state_reg;
  logic [31:0] sq_reg, num_reg, den_reg, ratio_q_reg, pow_reg;
  logic [32:0] rem_reg, rem_sh;
  logic [5:0] div_cnt_reg;
  logic [3:0] bit_reg;
  logic [4:0] exp_cnt_reg;
  logic [15:0] root_reg, mag_reg, l12_reg, l23_reg, l31_reg, trial;
  logic [16:0] ratio_pct_reg;
  logic [18:0] inverse_delay_mode_reg, op_cnt_reg, expect_reg, elapsed, target;
  logic signed [19:0] remain_reg;
  logic blk_s_reg, pick_reg, ub_reg, start_reg, trip_reg, blocked_reg;
  logic pick_n, ub_n, go, met;
  svp_pkg::svp_mode_t mode;
  svp_pkg::svp_force_t force_sel;

  assign mode = svp_pkg::svp_mode_t'(ctrl_reg[svp_pkg::CB_MODE_HI:svp_pkg::CB_MODE_LO]);
  assign force_sel = svp_pkg::svp_force_t'(ctrl_reg[svp_pkg::CB_FORCE_HI:svp_pkg::CB_FORCE_LO]);

  // rotate by 120 or 240 degrees, scaled by cos 30
  function automatic logic signed [19:0] cmul(input logic signed [15:0] v);
    logic signed [35:0] p;
    p = 36'(v) * 36'(svp_pkg::ROT_COS);
    return 20'(p >>> svp_pkg::ROT_SHIFT);
  endfunction

  function automatic logic signed [17:0] third(input logic signed [19:0] v);
    logic signed [39:0] p;
    p = 40'(v) * 40'(svp_pkg::THIRD);
    return 18'(p >>> svp_pkg::THIRD_SHIFT);
  endfunction

  // sequence phasor: b is rotated by 120, c by 240
  logic signed [15:0] b_re, b_im, c_re, c_im;
  logic signed [19:0] s_re, s_im;
  logic signed [17:0] q_re, q_im;
  logic [35:0] sq_wide;
  always_comb
  begin
    if (ctrl_reg[svp_pkg::CB_SEQ])
    begin
      b_re = ph3_re;
      b_im = ph3_im;
      c_re = ph2_re;
      c_im = ph2_im;
    end
    else
    begin
      b_re = ph2_re;
      b_im = ph2_im;
      c_re = ph3_re;
      c_im = ph3_im;
    end
  end

  always_comb
  begin
    s_re = 20'(ph1_re) - 20'(b_re >>> 1) - cmul(b_im) - 20'(c_re >>> 1) + cmul(c_im);
    s_im = 20'(ph1_im) + cmul(b_re) - 20'(b_im >>> 1) - cmul(c_re) - 20'(c_im >>> 1);
    q_re = third(s_re);
    q_im = third(s_im);
    sq_wide = 36'(q_re * q_re) + 36'(q_im * q_im);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_cnt_reg <= '0;
    else if (tick)
      tick_cnt_reg <= '0;
    else
      tick_cnt_reg <= tick_cnt_reg + svp_pkg::TICK_CNT_ONE;
  end
  assign tick = (tick_cnt_reg == 19'(TICK_CYCLES - 1));

  // apb decode, zero wait states
  always_comb
  begin
    unique case (paddr)
      svp_pkg::OFS_CTRL, svp_pkg::OFS_PICKUP, svp_pkg::OFS_UNDER_BLOCK_LEVEL, svp_pkg::OFS_DTDLY,
      svp_pkg::OFS_KDIAL, svp_pkg::OFS_AEXP, svp_pkg::OFS_RELDLY, svp_pkg::OFS_STATUS,
      svp_pkg::OFS_MAG, svp_pkg::OFS_RATIO, svp_pkg::OFS_EXPECT, svp_pkg::OFS_REMAIN:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en = psel & penable & pwrite & addr_ok;
  assign prdata = prdata_reg;

  // settings writable while running, clamped to range
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= svp_pkg::CTRL_RST;
      pickup_reg <= svp_pkg::PICKUP_RST;
      under_block_level_reg <= svp_pkg::UNDER_BLOCK_LEVEL_RST;
      dtdly_reg <= svp_pkg::DTDLY_RST;
      kdial_reg <= svp_pkg::KDIAL_RST;
      aexp_reg <= svp_pkg::AEXP_RST;
      reldly_reg <= svp_pkg::RELDLY_RST;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        svp_pkg::OFS_CTRL: ctrl_reg <= pwdata[9:0];
        svp_pkg::OFS_PICKUP: pickup_reg <= (pwdata[15:0] < svp_pkg::PICKUP_MIN) ?
          svp_pkg::PICKUP_MIN : (pwdata[15:0] > svp_pkg::PICKUP_MAX) ?
          svp_pkg::PICKUP_MAX : pwdata[15:0];
        svp_pkg::OFS_UNDER_BLOCK_LEVEL: under_block_level_reg <= (pwdata[15:0] > svp_pkg::UNDER_BLOCK_LEVEL_MAX) ?
          svp_pkg::UNDER_BLOCK_LEVEL_MAX : pwdata[15:0];
        svp_pkg::OFS_DTDLY: dtdly_reg <= (pwdata[18:0] > svp_pkg::TIME_MAX) ?
          svp_pkg::TIME_MAX : pwdata[18:0];
        svp_pkg::OFS_KDIAL: kdial_reg <= (pwdata[12:0] > svp_pkg::KDIAL_MAX) ?
          svp_pkg::KDIAL_MAX : pwdata[12:0];
        svp_pkg::OFS_AEXP: aexp_reg <= (pwdata[11:0] > svp_pkg::AEXP_MAX) ?
          svp_pkg::AEXP_MAX : pwdata[11:0];
        svp_pkg::OFS_RELDLY: reldly_reg <= (pwdata[14:0] > svp_pkg::RELDLY_MAX) ?
          svp_pkg::RELDLY_MAX : pwdata[14:0];
        default: ;
      endcase
    end
  end

  // read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= '0;
    else if (psel & ~penable & ~pwrite)
    begin
      unique case (paddr)
        svp_pkg::OFS_CTRL: prdata_reg <= 32'(ctrl_reg);
        svp_pkg::OFS_PICKUP: prdata_reg <= 32'(pickup_reg);
        svp_pkg::OFS_UNDER_BLOCK_LEVEL: prdata_reg <= 32'(under_block_level_reg);
        svp_pkg::OFS_DTDLY: prdata_reg <= 32'(dtdly_reg);
        svp_pkg::OFS_KDIAL: prdata_reg <= 32'(kdial_reg);
        svp_pkg::OFS_AEXP: prdata_reg <= 32'(aexp_reg);
        svp_pkg::OFS_RELDLY: prdata_reg <= 32'(reldly_reg);
        svp_pkg::OFS_STATUS: prdata_reg <= 32'({ub_reg, pick_reg, blocked, trip, start});
        svp_pkg::OFS_MAG: prdata_reg <= 32'(mag_reg);
        svp_pkg::OFS_RATIO: prdata_reg <= 32'(ratio_pct_reg);
        svp_pkg::OFS_EXPECT: prdata_reg <= 32'(expect_reg);
        svp_pkg::OFS_REMAIN: prdata_reg <= 32'(signed'(remain_reg));
        default: prdata_reg <= '0;
      endcase
    end
  end

  // shared restoring divider step and square root trial
  assign rem_sh = {rem_reg[31:0], num_reg[31]};
  assign trial = root_reg | (16'h0001 << bit_reg);

  // measurement sequencer, one pass per tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= SVP_IDLE;
      sq_reg <= '0;
      root_reg <= '0;
      bit_reg <= '0;
      num_reg <= '0;
      den_reg <= '0;
      rem_reg <= '0;
      div_cnt_reg <= '0;
      ratio_q_reg <= '0;
      pow_reg <= '0;
      exp_cnt_reg <= '0;
      mag_reg <= '0;
      ratio_pct_reg <= '0;
      inverse_delay_mode_reg <= svp_pkg::TIME_MAX;
      blk_s_reg <= 1'b0;
      l12_reg <= '0;
      l23_reg <= '0;
      l31_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        SVP_IDLE:
          if (tick)
          begin
            blk_s_reg <= block_in;
            sq_reg <= 32'(sq_wide);
            l12_reg <= line12_mag;
            l23_reg <= line23_mag;
            l31_reg <= line31_mag;
            root_reg <= '0;
            bit_reg <= svp_pkg::SQRT_TOP;
            state_reg <= SVP_SQRT;
          end
        SVP_SQRT:
        begin
          if (32'(trial) * 32'(trial) <= sq_reg)
            root_reg <= trial;
          if (bit_reg == '0)
          begin
            mag_reg <= (32'(trial) * 32'(trial) <= sq_reg) ? trial : root_reg;
            num_reg <= {((32'(trial) * 32'(trial) <= sq_reg) ? trial : root_reg), 16'h0000} >>
              (16 - svp_pkg::RQ);
            den_reg <= 32'(pickup_reg);
            rem_reg <= '0;
            div_cnt_reg <= svp_pkg::DIV_STEPS;
            state_reg <= SVP_RDIV;
          end
          else
            bit_reg <= bit_reg - 4'h1;
        end
        SVP_RDIV, SVP_TDIV:
        begin
          if (div_cnt_reg != '0)
          begin
            div_cnt_reg <= div_cnt_reg - 6'h01;
            rem_reg <= (rem_sh >= 33'(den_reg)) ? rem_sh - 33'(den_reg) : rem_sh;
            num_reg <= {num_reg[30:0], rem_sh >= 33'(den_reg)};
          end
          else if (state_reg == SVP_RDIV)
          begin
            ratio_q_reg <= (num_reg > svp_pkg::RQ_CAP) ? svp_pkg::RQ_CAP : num_reg;
            pow_reg <= (num_reg > svp_pkg::RQ_CAP) ? svp_pkg::RQ_CAP : num_reg;
            ratio_pct_reg <= ((39'(num_reg) * 39'(svp_pkg::PCT)) >> svp_pkg::RQ) >
              39'(svp_pkg::RATIO_MAX) ? svp_pkg::RATIO_MAX :
              17'((39'(num_reg) * 39'(svp_pkg::PCT)) >> svp_pkg::RQ);
            exp_cnt_reg <= 5'((aexp_reg + (svp_pkg::AEXP_UNIT >> 1)) / svp_pkg::AEXP_UNIT);
            state_reg <= SVP_POW;
          end
          else
          begin
            inverse_delay_mode_reg <= (num_reg > 32'(svp_pkg::TIME_MAX)) ? svp_pkg::TIME_MAX : num_reg[18:0];
            state_reg <= SVP_EVAL;
          end
        end
        // ratio raised to the rounded exponent, then k over the gap
        SVP_POW:
          if (exp_cnt_reg > 5'h01)
          begin
            exp_cnt_reg <= exp_cnt_reg - 5'h01;
            pow_reg <= ((64'(pow_reg) * 64'(ratio_q_reg)) >> svp_pkg::RQ) > 64'(svp_pkg::RQ_CAP) ?
              svp_pkg::RQ_CAP : 32'((64'(pow_reg) * 64'(ratio_q_reg)) >> svp_pkg::RQ);
          end
          else if (ctrl_reg[svp_pkg::CB_UNDER] ? (pow_reg >= svp_pkg::RQ_ONE) :
                   (pow_reg <= svp_pkg::RQ_ONE))
          begin
            inverse_delay_mode_reg <= svp_pkg::TIME_MAX;
            state_reg <= SVP_EVAL;
          end
          else
          begin
            num_reg <= 32'(kdial_reg) * 32'(svp_pkg::TICKS_PER_CS) << svp_pkg::RQ;
            den_reg <= ctrl_reg[svp_pkg::CB_UNDER] ? svp_pkg::RQ_ONE - pow_reg :
              pow_reg - svp_pkg::RQ_ONE;
            rem_reg <= '0;
            div_cnt_reg <= svp_pkg::DIV_STEPS;
            state_reg <= SVP_TDIV;
          end
        SVP_EVAL:
          state_reg <= SVP_OUT;
        // outputs refresh in this cycle, then wait for the next tick
        SVP_OUT:
          state_reg <= SVP_IDLE;
      endcase
    end
  end

  // pick-up comparison with fixed hysteresis
  always_comb
  begin
    if (!ctrl_reg[svp_pkg::CB_UNDER])
      pick_n = pick_reg ? !(23'(mag_reg) * 23'(svp_pkg::PCT) <
        23'(pickup_reg) * 23'(svp_pkg::HYS_OVER)) : (mag_reg > pickup_reg);
    else
      pick_n = pick_reg ? !(23'(mag_reg) * 23'(svp_pkg::PCT) >
        23'(pickup_reg) * 23'(svp_pkg::HYS_UNDER)) : (mag_reg < pickup_reg);
    // zero level disables, latch until all lines recover
    if (!ctrl_reg[svp_pkg::CB_UNDER] || under_block_level_reg == '0)
      ub_n = 1'b0;
    else if (mag_reg < under_block_level_reg)
      ub_n = 1'b1;
    else if (l12_reg > pickup_reg && l23_reg > pickup_reg && l31_reg > pickup_reg)
      ub_n = 1'b0;
    else
      ub_n = ub_reg;
    go = pick_n & ~blk_s_reg;
    elapsed = start_reg ? op_cnt_reg + svp_pkg::TICK_CNT_ONE : '0;
    unique case (mode)
      svp_pkg::SVP_DEFINITE: target = dtdly_reg;
      svp_pkg::SVP_INVERSE: target = inverse_delay_mode_reg;
      default: target = '0;
    endcase
    met = (elapsed >= target);
  end

  // stage status, release and operate timers, once per tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pick_reg <= 1'b0;
      ub_reg <= 1'b0;
      start_reg <= 1'b0;
      trip_reg <= 1'b0;
      blocked_reg <= 1'b0;
      op_cnt_reg <= '0;
      rel_cnt_reg <= '0;
      expect_reg <= '0;
      remain_reg <= '0;
    end
    else if (state_reg == SVP_EVAL)
    begin
      pick_reg <= pick_n;
      ub_reg <= ub_n;
      blocked_reg <= pick_n & blk_s_reg;
      expect_reg <= target;
      remain_reg <= signed'(20'(target)) - signed'(20'(elapsed));
      // trip held off by under blocking
      trip_reg <= go & ~ub_n & met;
      if (start_reg && !go)
      begin
        // release handling on drop or block
        if (ctrl_reg[svp_pkg::CB_DLYREL] && rel_cnt_reg < reldly_reg)
        begin
          rel_cnt_reg <= rel_cnt_reg + 15'h0001;
          if (!ctrl_reg[svp_pkg::CB_CALCRST])
            op_cnt_reg <= '0;
          else if (ctrl_reg[svp_pkg::CB_CONT])
            op_cnt_reg <= elapsed;
        end
        else
        begin
          start_reg <= 1'b0;
          op_cnt_reg <= '0;
          rel_cnt_reg <= '0;
        end
      end
      else if (go)
      begin
        // start and run the operate timer
        start_reg <= 1'b1;
        rel_cnt_reg <= '0;
        op_cnt_reg <= elapsed;
      end
    end
  end

  // forced status overrides outputs, applied once per pass
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start <= 1'b0;
      trip <= 1'b0;
      blocked <= 1'b0;
    end
    else if (state_reg == SVP_OUT)
    begin
      if (ctrl_reg[svp_pkg::CB_FORCE_EN])
      begin
        start <= (force_sel == svp_pkg::SVP_F_START) || (force_sel == svp_pkg::SVP_F_TRIP);
        trip <= (force_sel == svp_pkg::SVP_F_TRIP);
        blocked <= (force_sel == svp_pkg::SVP_F_BLOCKED);
      end
      else
      begin
        start <= start_reg;
        trip <= trip_reg;
        blocked <= blocked_reg;
      end
    end
  end
endmodule

// ### verification/svp_seq_voltage_stage_sva.sv
module svp_seq_voltage_stage_sva #(
  parameter int unsigned TICK_CYCLES = 200
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic start,
  input wire logic trip,
  input wire logic blocked
);
  logic [31:0] tk;
  logic bad_addr;
  default clocking dck @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // cycles since the last processing tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tk <= 32'h0;
    else if (tk == TICK_CYCLES - 1)
      tk <= 32'h0;
    else
      tk <= tk + 32'h1;
  end
  // addresses beyond the last register or off a word boundary
  assign bad_addr = (paddr > svp_pkg::OFS_REMAIN) || (paddr[1:0] != 2'h0);
  // bus phases
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  property p_zero_wait;
    s_setup ##1 s_access |-> pready;
  endproperty
  property p_err_bad;
    s_access ##0 bad_addr |-> pslverr;
  endproperty
  property p_err_only;
    pslverr |-> psel && penable && bad_addr;
  endproperty
  property p_trip_start;
    trip |-> start;
  endproperty
  property p_trip_blk;
    trip |-> !blocked;
  endproperty
  property p_out_tick;
    !$stable({start, trip, blocked}) |-> tk < 32'h96;
  endproperty
  property p_start_hold;
    $rose(start) |=> start [*8];
  endproperty
  property p_blk_hold;
    $rose(blocked) |=> blocked [*8];
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("access not ready");
  a_err_bad: assert property (p_err_bad) else $error("no error on bad address");
  a_err_only: assert property (p_err_only) else $error("stray error");
  a_trip_start: assert property (p_trip_start) else $error("trip without start");
  a_trip_blk: assert property (p_trip_blk) else $error("trip while blocked");
  a_out_tick: assert property (p_out_tick) else $error("output off pass");
  a_start_hold: assert property (p_start_hold) else $error("start glitch");
  a_blk_hold: assert property (p_blk_hold) else $error("blocked glitch");
endmodule

bind svp_seq_voltage_stage svp_seq_voltage_stage_sva #(.TICK_CYCLES(TICK_CYCLES))
  i_svp_seq_voltage_stage_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .start(start), .trip(trip), .blocked(blocked)
);

// ### verification/svp_front_end.sv
module svp_front_end (
  input wire logic pclk,
  output logic signed [15:0] ph1_re,
  output logic signed [15:0] ph1_im,
  output logic signed [15:0] ph2_re,
  output logic signed [15:0] ph2_im,
  output logic signed [15:0] ph3_re,
  output logic signed [15:0] ph3_im,
  output logic [15:0] line12_mag,
  output logic [15:0] line23_mag,
  output logic [15:0] line31_mag,
  output logic block_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // balanced phasors, phase two lags by 120 degrees
  task automatic levels(input logic [15:0] v, input logic [15:0] l);
    logic [31:0] q;
    q = 32'(v) * 32'h362 / 32'h3e8;
    ph1_re <= $signed(v);
    ph1_im <= 16'sh0;
    ph2_re <= $signed(16'h0 - (v >> 1));
    ph2_im <= $signed(16'h0 - q[15:0]);
    ph3_re <= $signed(16'h0 - (v >> 1));
    ph3_im <= $signed(q[15:0]);
    line12_mag <= l;
    line23_mag <= l;
    line31_mag <= l;
  endtask
  // dead network and no blocking at start
  initial
  begin
    levels(16'h0, 16'h0);
    block_in <= 1'b0;
  end
  task automatic set_volts(input logic [15:0] v, input logic [15:0] l);
    @(posedge pclk);
    levels(v, l);
  endtask
  task automatic set_block(input logic b);
    @(posedge pclk);
    block_in <= b;
  endtask
endmodule

// ### verification/svp_seq_voltage_stage_bench.sv
module svp_seq_voltage_stage_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TICKS = 200;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, start, trip, blocked, last_err;
  logic signed [15:0] ph1_re, ph1_im, ph2_re, ph2_im, ph3_re, ph3_im;
  logic [15:0] line12_mag, line23_mag, line31_mag;
  logic block_in;
  int checks = 0;
  int fail_count = 0;
  logic [31:0] dval [7] = '{32'h74, 32'h2904, 32'h1f4, 32'h8, 32'h5, 32'h64, 32'hc};
  logic [2:0] fexp [4] = '{3'h0, 3'h4, 3'h6, 3'h1};
  always #5 pclk = ~pclk;
  svp_seq_voltage_stage #(.TICK_CYCLES(TICKS)) i_svp_seq_voltage_stage (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ph1_re(ph1_re), .ph1_im(ph1_im), .ph2_re(ph2_re), .ph2_im(ph2_im), .ph3_re(ph3_re),
    .ph3_im(ph3_im), .line12_mag(line12_mag), .line23_mag(line23_mag),
    .line31_mag(line31_mag), .block_in(block_in), .start(start), .trip(trip),
    .blocked(blocked)
  );
  svp_front_end i_svp_front_end (
    .pclk(pclk), .ph1_re(ph1_re), .ph1_im(ph1_im), .ph2_re(ph2_re), .ph2_im(ph2_im),
    .ph3_re(ph3_re), .ph3_im(ph3_im), .line12_mag(line12_mag), .line23_mag(line23_mag),
    .line31_mag(line31_mag), .block_in(block_in)
  );
  // one bus transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    check(s, q, e);
  endtask
  task automatic rd_in(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi,
    input string s);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    check(s, 32'(q >= lo && q <= hi), 32'h1);
  endtask
  // wait whole passes, then compare start, trip, blocked
  task automatic outs(input int n, input logic [2:0] e, input string s);
    repeat (n * TICKS) @(posedge pclk);
    // sample away from the edge that updates the outputs
    @(negedge pclk);
    check(s, 32'({start, trip, blocked}), 32'(e));
    @(posedge pclk);
  endtask
  task automatic go(input logic [15:0] v, input logic [15:0] l, input logic [2:0] e,
    input string s);
    i_svp_front_end.set_volts(v, l);
    outs(2, e, s);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog
  initial
  begin
    repeat (90 * TICKS) @(posedge pclk);
    fail_count++;
    wrap_up();
  end
  // main sequence
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 7; i++)
      rd(8'(4 * i), dval[i], "default");
    rd(8'h40, 32'h0, "unmapped");
    check("pslverr", 32'(last_err), 32'h1);
    wr(8'h1c, 32'h7);
    rd(8'h1c, 32'h0, "status ro");
    wr(8'h04, 32'h64);
    rd(8'h04, 32'(svp_pkg::PICKUP_MIN), "pickup min");
    wr(8'h04, 32'h4e20);
    rd(8'h04, 32'(svp_pkg::PICKUP_MAX), "pickup max");
    wr(8'h08, 32'h2328);
    rd(8'h08, 32'(svp_pkg::UNDER_BLOCK_LEVEL_MAX), "under_block_level max");
    $display("test registers done");
    wr(8'h04, 32'h2904);
    wr(8'h00, 32'h0);
    go(16'h2af8, 16'h2af8, 3'h6, "over pick");
    rd_in(8'h20, 32'h2ac6, 32'h2b2a, "pos mag");
    rd_in(8'h24, 32'h68, 32'h69, "ratio");
    go(16'h283c, 16'h283c, 3'h6, "over hold");
    go(16'h2774, 16'h2774, 3'h0, "over drop");
    wr(8'h00, 32'h1);
    go(16'h2af8, 16'h2af8, 3'h0, "neg sel");
    rd_in(8'h20, 32'h0, 32'h28, "neg mag");
    $display("test over done");
    wr(8'h04, 32'h1f40);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h2);
    go(16'h1b58, 16'h1b58, 3'h6, "under pick");
    go(16'h1fa4, 16'h1fa4, 3'h6, "under hold");
    go(16'h2134, 16'h2134, 3'h0, "under drop");
    go(16'h012c, 16'h012c, 3'h6, "under_block_level off");
    wr(8'h08, 32'h1f4);
    go(16'h012c, 16'h012c, 3'h4, "under_block_level on");
    rd(8'h1c, 32'h19, "status");
    go(16'h1b58, 16'h1b58, 3'h4, "under_block_level held");
    go(16'h1b58, 16'h2328, 3'h6, "under_block_level clear");
    $display("test under done");
    wr(8'h04, 32'h2904);
    wr(8'h00, 32'h0);
    go(16'h2710, 16'h2710, 3'h0, "idle");
    i_svp_front_end.set_block(1'b1);
    go(16'h2af8, 16'h2af8, 3'h1, "blocked pick");
    i_svp_front_end.set_block(1'b0);
    outs(2, 3'h6, "unblock");
    i_svp_front_end.set_block(1'b1);
    outs(2, 3'h1, "block in start");
    go(16'h2710, 16'h2710, 3'h0, "block drop");
    i_svp_front_end.set_block(1'b0);
    $display("test blocking done");
    wr(8'h0c, 32'h4);
    wr(8'h00, 32'h4);
    go(16'h2af8, 16'h2af8, 3'h4, "dt start");
    rd(8'h28, 32'h4, "expect");
    rd_in(8'h2c, 32'h1, 32'h4, "remain");
    outs(4, 3'h6, "dt trip");
    wr(8'h18, 32'h8);
    wr(8'h00, 32'h14);
    go(16'h2710, 16'h2710, 3'h4, "rel hold");
    outs(9, 3'h0, "rel end");
    wr(8'h00, 32'h8);
    go(16'h2af8, 16'h2af8, 3'h4, "inv start");
    rd_in(8'h28, 32'hbe, 32'he6, "inv time");
    go(16'h2ee0, 16'h2ee0, 3'h4, "inv rise");
    rd_in(8'h28, 32'h41, 32'h4b, "inv update");
    wr(8'h00, 32'hc);
    outs(2, 3'h6, "mode 3 instant");
    go(16'h2710, 16'h2710, 3'h0, "inv drop");
    $display("test timing done");
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h00, 32'h80 | (32'(c) << 8));
      outs(2, fexp[c], "force");
    end
    wr(8'h00, 32'h200);
    outs(2, 3'h0, "force off");
    $display("test force done");
    wrap_up();
  end
endmodule
